/* hdl/sbsr_consts.vh */
// Purpose: shared constants of the status byte and service request block
// Assumes: included by bare name from every sbsr design file
// Notes: command codes are local to this block's command port
`ifndef SBSR_CONSTS_VH
`define SBSR_CONSTS_VH

// Command codes on cmd_code
`define SBSR_CMD_W 4
`define SBSR_CMD_ESR_QUERY 4'h1
`define SBSR_CMD_ESE_WRITE 4'h2
`define SBSR_CMD_ESE_QUERY 4'h3
`define SBSR_CMD_STB_QUERY 4'h4
`define SBSR_CMD_SRE_WRITE 4'h5
`define SBSR_CMD_SRE_QUERY 4'h6
`define SBSR_CMD_CLEAR_STATUS 4'h7
`define SBSR_CMD_SERIAL_POLL 4'h8
`define SBSR_CMD_ERR_QUERY 4'h9
`define SBSR_CMD_PROT_EN_WRITE 4'hA
`define SBSR_CMD_PROT_EN_QUERY 4'hB
`define SBSR_CMD_PROT_EV_QUERY 4'hC

// Standard event flag bits
`define SBSR_EV_OPC 0
`define SBSR_EV_QUERY_ERR 2
`define SBSR_EV_DEV_ERR 3
`define SBSR_EV_EXEC_ERR 4
`define SBSR_EV_CMD_ERR 5
`define SBSR_EV_POWER_ON 7
`define SBSR_EV_USED_MASK 8'hBD
`define SBSR_EV_RESET 8'h80

// Status byte bits
`define SBSR_SB_SPARE 0
`define SBSR_SB_PROT 1
`define SBSR_SB_ERRQ 2
`define SBSR_SB_QUEST 3
`define SBSR_SB_MAV 4
`define SBSR_SB_ESB 5
`define SBSR_SB_RQS 6
`define SBSR_SB_OPER 7
`define SBSR_SB_NO_RQS_MASK 8'hBF

// Reset values and widths
`define SBSR_MASK_RESET 8'h00
`define SBSR_BYTE_ZERO 8'h00
`define SBSR_RSP_W 32
`define SBSR_ERR_NONE 16'h0000

`endif

/* hdl/sbsr_err_queue.v */
// Purpose: first-in first-out error queue of the status block
// Assumes: one push and one pop per cycle at most
// Notes: a push into a full queue is dropped unless a pop or flush comes in that cycle; flush with push keeps the push
`timescale 1ns/1ns
`default_nettype none
`include "sbsr_consts.vh"
module sbsr_err_queue #(
  parameter W = 16,
  parameter DEPTH = 10,
  parameter AW = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Fill side
  input wire push,
  input wire [W-1:0] push_data,
  // Drain side
  input wire pop,
  input wire flush,
  output wire [W-1:0] head,
  output wire not_empty,
  output wire full
);
  localparam [AW-1:0] LAST = DEPTH - 1;
  localparam [AW:0] CNT_FULL = DEPTH;
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  reg [AW-1:0] nxt_wr_ptr;
  reg [AW-1:0] nxt_rd_ptr;
  reg [AW:0] nxt_count;
  wire [W*DEPTH-1:0] flat;
  wire pop_ok;
  wire push_ok;
  wire [AW-1:0] wr_idx;

  assign not_empty = (count_ff != {(AW+1){1'b0}});
  assign full = (count_ff == CNT_FULL);
  assign pop_ok = pop & not_empty & ~flush;
  // Full queue still takes a push when an entry leaves in the same cycle
  assign push_ok = push & (~full | pop_ok | flush);
  assign wr_idx = flush ? {AW{1'b0}} : wr_ptr_ff;
  assign head = flat[rd_ptr_ff*W +: W];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
      reg [W-1:0] entry_ff;
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          entry_ff <= {W{1'b0}};
        end else if (push_ok && wr_idx == i) begin
          entry_ff <= push_data;
        end
      end
      assign flat[i*W +: W] = entry_ff;
    end
  endgenerate

  always @* begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    if (flush) begin
      nxt_rd_ptr = {AW{1'b0}};
      nxt_wr_ptr = push_ok ? {{(AW-1){1'b0}}, 1'b1} : {AW{1'b0}};
      nxt_count = push_ok ? {{AW{1'b0}}, 1'b1} : {(AW+1){1'b0}};
    end else begin
      if (push_ok) begin
        nxt_wr_ptr = (wr_ptr_ff == LAST) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (pop_ok) begin
        nxt_rd_ptr = (rd_ptr_ff == LAST) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (push_ok && !pop_ok) begin
        nxt_count = count_ff + 1'b1;
      end else if (pop_ok && !push_ok) begin
        nxt_count = count_ff - 1'b1;
      end
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
    end
  end
endmodule
`default_nettype wire

/* hdl/sbsr_prot_latch.v */
// Purpose: protection event latch with its enable mask
// Assumes: cond carries the protection conditions, one bit per fault
// Notes: a new event in the clearing cycle survives the clear
`timescale 1ns/1ns
`default_nettype none
`include "sbsr_consts.vh"
module sbsr_prot_latch #(
  parameter W = 21
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Conditions from the power stage
  input wire [W-1:0] cond,
  // Enable mask access
  input wire en_wr,
  input wire [W-1:0] en_data,
  // Clearing
  input wire rd_clr,
  input wire cls,
  // Latched state
  output reg [W-1:0] en_ff,
  output reg [W-1:0] evt_ff
);
  wire [W-1:0] nxt_evt;
  // Only enabled faults latch; hold until read or cleared
  assign nxt_evt = ((rd_clr | cls) ? {W{1'b0}} : evt_ff) | (cond & en_ff);

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_ff <= {W{1'b0}};
      evt_ff <= {W{1'b0}};
    end else begin
      evt_ff <= nxt_evt;
      if (en_wr) begin
        en_ff <= en_data;
      end
    end
  end
endmodule
`default_nettype wire

/* hdl/sbsr_status_top.v */
// Purpose: status byte, standard event flags and service request logic
// Assumes: commands arrive already parsed from the host interface
// Notes: one command per cycle; queries answer on the following cycle
`timescale 1ns/1ns
`default_nettype none
`include "sbsr_consts.vh"

module sbsr_status_top #(
  parameter PROT_W = 21,
  parameter ERR_W = 16,
  parameter ERR_DEPTH = 10,
  parameter ERR_AW = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Command port from the host interface parser
  input wire cmd_valid,
  input wire [`SBSR_CMD_W-1:0] cmd_code,
  input wire [`SBSR_RSP_W-1:0] cmd_data,
  // Query answers
  output reg rsp_valid_ff,
  output reg [`SBSR_RSP_W-1:0] rsp_data_ff,
  // Event sources
  input wire [7:0] std_event_set,
  input wire [PROT_W-1:0] prot_cond,
  input wire err_push,
  input wire [ERR_W-1:0] err_code,
  input wire output_message_waiting,
  input wire gpib_mode,
  // Service request line, open drain, low when requesting
  output reg srq_o_ff,
  output reg srq_oe_ff,
  // Status views
  output reg [7:0] summary_status_byte_ff,
  output reg request_service_flag_ff,
  output reg err_full_ff
);
  // Architected registers
  reg [7:0] standard_event_flags_ff;
  reg [7:0] standard_event_mask_ff;
  reg [7:0] service_request_mask_ff;
  reg summary_prev_ff;
  // Next values
  reg [7:0] nxt_flags;
  reg nxt_rqs;
  reg nxt_srq_oe;
  reg [`SBSR_RSP_W-1:0] nxt_rsp_data;
  reg nxt_rsp_valid;
  // Decoded command strobes
  reg flags_rd;
  reg ese_wr;
  reg sre_wr;
  reg cls;
  reg spoll;
  reg err_rd;
  reg prot_en_wr;
  reg prot_ev_rd;
  reg cmd_bad;
  // Sub-block views
  wire [PROT_W-1:0] prot_en;
  wire [PROT_W-1:0] prot_evt;
  wire [ERR_W-1:0] err_head;
  wire err_not_empty;
  wire err_full;
  // Status byte assembly
  wire [7:0] esr_enabled;
  wire esb;
  wire [7:0] sb_core;
  wire [7:0] sb_gated;
  wire summary;
  wire [7:0] stb_query_val;
  wire [7:0] spoll_val;

  // Decode of one command per cycle
  always @* begin
    flags_rd = 1'b0;
    ese_wr = 1'b0;
    sre_wr = 1'b0;
    cls = 1'b0;
    spoll = 1'b0;
    err_rd = 1'b0;
    prot_en_wr = 1'b0;
    prot_ev_rd = 1'b0;
    cmd_bad = 1'b0;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data = {`SBSR_RSP_W{1'b0}};
    if (cmd_valid) begin
      case (cmd_code)
        `SBSR_CMD_ESR_QUERY: begin
          flags_rd = 1'b1;
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data[7:0] = standard_event_flags_ff;
        end
        `SBSR_CMD_ESE_WRITE: begin
          ese_wr = 1'b1;
        end
        `SBSR_CMD_ESE_QUERY: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data[7:0] = standard_event_mask_ff;
        end
        `SBSR_CMD_STB_QUERY: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data[7:0] = stb_query_val;
        end
        `SBSR_CMD_SRE_WRITE: begin
          sre_wr = 1'b1;
        end
        `SBSR_CMD_SRE_QUERY: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data[7:0] = service_request_mask_ff;
        end
        `SBSR_CMD_CLEAR_STATUS: begin
          cls = 1'b1;
        end
        `SBSR_CMD_SERIAL_POLL: begin
          // Serial poll exists only on GPIB; elsewhere it is refused silently
          if (gpib_mode) begin
            spoll = 1'b1;
            nxt_rsp_valid = 1'b1;
            nxt_rsp_data[7:0] = spoll_val;
          end
        end
        `SBSR_CMD_ERR_QUERY: begin
          err_rd = 1'b1;
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data[ERR_W-1:0] = err_not_empty ? err_head : `SBSR_ERR_NONE;
        end
        `SBSR_CMD_PROT_EN_WRITE: begin
          prot_en_wr = 1'b1;
        end
        `SBSR_CMD_PROT_EN_QUERY: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data[PROT_W-1:0] = prot_en;
        end
        `SBSR_CMD_PROT_EV_QUERY: begin
          prot_ev_rd = 1'b1;
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data[PROT_W-1:0] = prot_evt;
        end
        default: begin
          // Unknown command counts as a command error
          cmd_bad = 1'b1;
        end
      endcase
    end
  end

  // Standard event flags: new events win over the read or clear
  always @* begin
    nxt_flags = (flags_rd | cls) ? `SBSR_BYTE_ZERO : standard_event_flags_ff;
    nxt_flags = nxt_flags | (std_event_set & `SBSR_EV_USED_MASK);
    nxt_flags[`SBSR_EV_CMD_ERR] = nxt_flags[`SBSR_EV_CMD_ERR] | cmd_bad;
  end

  // Protection event latch feeding bit 1
  sbsr_prot_latch #(
    .W(PROT_W)
  ) u_prot (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cond(prot_cond),
    .en_wr(prot_en_wr),
    .en_data(cmd_data[PROT_W-1:0]),
    .rd_clr(prot_ev_rd),
    .cls(cls),
    .en_ff(prot_en),
    .evt_ff(prot_evt)
  );

  // Error queue feeding bit 2
  sbsr_err_queue #(
    .W(ERR_W),
    .DEPTH(ERR_DEPTH),
    .AW(ERR_AW)
  ) u_errq (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .push(err_push),
    .push_data(err_code),
    .pop(err_rd),
    .flush(cls),
    .head(err_head),
    .not_empty(err_not_empty),
    .full(err_full)
  );

  // Status byte sources; bits 0, 3 and 7 stay zero
  assign esr_enabled = standard_event_flags_ff & standard_event_mask_ff;
  assign esb = |esr_enabled;
  assign sb_core[`SBSR_SB_SPARE] = 1'b0;
  assign sb_core[`SBSR_SB_PROT] = |prot_evt;
  assign sb_core[`SBSR_SB_ERRQ] = err_not_empty;
  assign sb_core[`SBSR_SB_QUEST] = 1'b0;
  assign sb_core[`SBSR_SB_MAV] = output_message_waiting & gpib_mode;
  assign sb_core[`SBSR_SB_ESB] = esb;
  assign sb_core[`SBSR_SB_RQS] = 1'b0;
  assign sb_core[`SBSR_SB_OPER] = 1'b0;

  // Each bit passes only where its service mask bit is set;
  // bit 6 is left out to avoid a loop through its own mask bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sre_gate
      if (gi == `SBSR_SB_RQS) begin : g_self
        assign sb_gated[gi] = 1'b0;
      end else begin : g_bit
        assign sb_gated[gi] = sb_core[gi] & service_request_mask_ff[gi];
      end
    end
  endgenerate
  assign summary = |sb_gated;
  assign stb_query_val = sb_core | ({7'h00, summary} << `SBSR_SB_RQS);
  assign spoll_val = sb_core | ({7'h00, request_service_flag_ff} << `SBSR_SB_RQS);

  // Request service rises with a new reason on GPIB only; a poll or clear clears it, new reason wins
  always @* begin
    nxt_rqs = request_service_flag_ff;
    if (spoll || cls) begin
      nxt_rqs = 1'b0;
    end
    if (gpib_mode && summary && !summary_prev_ff) begin
      nxt_rqs = 1'b1;
    end
    // Line pulled low while service is requested on GPIB
    nxt_srq_oe = nxt_rqs & gpib_mode;
  end

  // Event flags and the two masks
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      standard_event_flags_ff <= `SBSR_EV_RESET;
      standard_event_mask_ff <= `SBSR_MASK_RESET;
      service_request_mask_ff <= `SBSR_MASK_RESET;
    end else begin
      standard_event_flags_ff <= nxt_flags;
      if (ese_wr) begin
        standard_event_mask_ff <= cmd_data[7:0];
      end
      if (sre_wr) begin
        service_request_mask_ff <= cmd_data[7:0];
      end
    end
  end

  // Request service state and the edge reference of the summary
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      summary_prev_ff <= 1'b0;
      request_service_flag_ff <= 1'b0;
    end else begin
      summary_prev_ff <= summary;
      request_service_flag_ff <= nxt_rqs;
    end
  end

  // Query answers; data holds until the next answer replaces it
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= {`SBSR_RSP_W{1'b0}};
    end else begin
      rsp_valid_ff <= nxt_rsp_valid;
      if (nxt_rsp_valid) begin
        rsp_data_ff <= nxt_rsp_data;
      end
    end
  end

  // Pin and status views, registered so outputs never glitch
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      summary_status_byte_ff <= `SBSR_BYTE_ZERO;
      srq_o_ff <= 1'b0;
      srq_oe_ff <= 1'b0;
      err_full_ff <= 1'b0;
    end else begin
      summary_status_byte_ff <= stb_query_val;
      // Open drain: data stays low, only the enable moves
      srq_o_ff <= 1'b0;
      srq_oe_ff <= nxt_srq_oe;
      err_full_ff <= err_full;
    end
  end
endmodule
`default_nettype wire

/* verif/sbsr_status_sva.sv */
// Purpose: port checks of the status byte block
// Assumes: the bench never pushes and pops the error queue together
// Notes: queue fill is mirrored in a small counter
`timescale 1ns/1ns
`default_nettype none
`include "sbsr_consts.vh"
module sbsr_status_sva #(
  parameter PROT_W = 21,
  parameter ERR_W = 16,
  parameter ERR_DEPTH = 10
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Command port
  input wire cmd_valid,
  input wire [`SBSR_CMD_W-1:0] cmd_code,
  input wire [`SBSR_RSP_W-1:0] cmd_data,
  input wire rsp_valid_ff,
  input wire [`SBSR_RSP_W-1:0] rsp_data_ff,
  // Event sources
  input wire [7:0] std_event_set,
  input wire [PROT_W-1:0] prot_cond,
  input wire err_push,
  input wire [ERR_W-1:0] err_code,
  input wire output_message_waiting,
  input wire gpib_mode,
  // Status outputs
  input wire srq_o_ff,
  input wire srq_oe_ff,
  input wire [7:0] summary_status_byte_ff,
  input wire request_service_flag_ff,
  input wire err_full_ff
);
  // Codes that answer: 1,3,4,6,9,B,C; the poll only on GPIB
  localparam [15:0] QMAP = 16'h1A5A;
  localparam [4:0] DEPTH5 = ERR_DEPTH;
  wire is_query = QMAP[cmd_code] || (cmd_code == `SBSR_CMD_SERIAL_POLL && gpib_mode);
  reg [4:0] nq_ff;
  reg [4:0] nxt_nq;
  always @* begin
    nxt_nq = nq_ff;
    if (cmd_valid && cmd_code == `SBSR_CMD_CLEAR_STATUS)
      nxt_nq = 5'h00;
    else if (cmd_valid && cmd_code == `SBSR_CMD_ERR_QUERY && nq_ff != 5'h00)
      nxt_nq = nq_ff - 5'h01;
    else if (err_push && nq_ff < DEPTH5)
      nxt_nq = nq_ff + 5'h01;
  end
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      nq_ff <= 5'h00;
    else
      nq_ff <= nxt_nq;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  unused_bits_zero_a: assert property ((summary_status_byte_ff & 8'h89) == 8'h00)
    else $error("unused status bit set");
  answer_taken_a: assert property (cmd_valid && is_query |=> rsp_valid_ff)
    else $error("query not answered");
  no_answer_a: assert property (!(cmd_valid && is_query) |=> !rsp_valid_ff)
    else $error("answer without query");
  srq_with_flag_a: assert property (srq_oe_ff |-> request_service_flag_ff && gpib_mode)
    else $error("service line without request");
  srq_drive_low_a: assert property (srq_o_ff == 1'b0)
    else $error("service line driven high");
  poll_clears_a: assert property (cmd_valid && cmd_code == `SBSR_CMD_SERIAL_POLL && gpib_mode
    && summary_status_byte_ff[6] |=> !request_service_flag_ff) else $error("poll kept request");
  flag_gpib_only_a: assert property ($rose(request_service_flag_ff) |-> $past(gpib_mode))
    else $error("request raised off GPIB");
  waiting_gpib_only_a: assert property (summary_status_byte_ff[4] |-> gpib_mode)
    else $error("message bit off GPIB");
  queue_bit_a: assert property (nxt_nq != 5'h00 |-> ##[1:2] summary_status_byte_ff[2])
    else $error("queue bit missing");
  queue_full_a: assert property (nxt_nq == DEPTH5 |-> ##[1:2] err_full_ff)
    else $error("queue full missing");
  srq_seen_c: cover property ($rose(srq_oe_ff));
  full_seen_c: cover property (err_full_ff);
  poll_refused_c: cover property (cmd_valid && cmd_code == `SBSR_CMD_SERIAL_POLL && !gpib_mode);
endmodule
bind sbsr_status_top sbsr_status_sva #(.PROT_W(PROT_W), .ERR_W(ERR_W), .ERR_DEPTH(ERR_DEPTH))
  sbsr_status_sva_inst (.sys_clk, .reset_n, .cmd_valid, .cmd_code, .cmd_data, .rsp_valid_ff,
  .rsp_data_ff, .std_event_set, .prot_cond, .err_push, .err_code, .output_message_waiting,
  .gpib_mode, .srq_o_ff, .srq_oe_ff, .summary_status_byte_ff, .request_service_flag_ff,
  .err_full_ff);
`default_nettype wire

/* verif/sbsr_host_model.sv */
// Purpose: remote host issuing parsed commands
// Assumes: commands launched on the falling edge
// Notes: the service line has a pull-up
`timescale 1ns/1ns
`default_nettype none
`include "sbsr_consts.vh"
module sbsr_host_model (
  // Clock
  input wire logic sys_clk,
  // Command port
  output logic cmd_valid,
  output logic [`SBSR_CMD_W-1:0] cmd_code,
  output logic [`SBSR_RSP_W-1:0] cmd_data,
  input wire logic rsp_valid_ff,
  input wire logic [`SBSR_RSP_W-1:0] rsp_data_ff,
  // Service request wire
  input wire logic srq_oe_ff,
  output wire logic srq_line
);
  assign srq_line = srq_oe_ff ? 1'b0 : 1'b1;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 4'h0;
    cmd_data = 32'h0;
  end
  // Answer is sampled in the one cycle it stands
  task automatic xfer(input logic [3:0] c, input logic [31:0] d, output logic v,
    output logic [31:0] r);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_code = ~c;
    cmd_data = ~d;
    v = rsp_valid_ff;
    r = rsp_data_ff;
  endtask
endmodule
`default_nettype wire

/* verif/status_byte_service_request_tb.sv */
// Purpose: self-checking bench of the status byte block
// Assumes: inputs change on the falling edge
// Notes: expected values come from the status bit map
`timescale 1ns/1ns
`default_nettype none
`include "sbsr_consts.vh"
module status_byte_service_request_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid, rsp_valid_ff, srq_o_ff, srq_oe_ff, srq_line;
  logic request_service_flag_ff, err_full_ff;
  logic [3:0] cmd_code;
  logic [31:0] cmd_data, rsp_data_ff;
  logic [7:0] summary_status_byte_ff;
  logic [7:0] std_event_set = 8'h00;
  logic [20:0] prot_cond = 21'h0;
  logic err_push = 1'b0;
  logic output_message_waiting = 1'b0;
  logic gpib_mode = 1'b0;
  logic [15:0] err_code = 16'h0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #4 sys_clk = ~sys_clk;
  sbsr_status_top sbsr_status_top_inst (.sys_clk, .reset_n, .cmd_valid, .cmd_code, .cmd_data,
    .rsp_valid_ff, .rsp_data_ff, .std_event_set, .prot_cond, .err_push, .err_code,
    .output_message_waiting, .gpib_mode, .srq_o_ff, .srq_oe_ff, .summary_status_byte_ff,
    .request_service_flag_ff, .err_full_ff);
  sbsr_host_model sbsr_host_model_inst (.sys_clk, .cmd_valid, .cmd_code, .cmd_data,
    .rsp_valid_ff, .rsp_data_ff, .srq_oe_ff, .srq_line);
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic ask(input logic [3:0] c, input logic [31:0] exp);
    logic v;
    logic [31:0] r;
    sbsr_host_model_inst.xfer(c, 32'h0, v, r);
    check("answer strobe", 32'h1, {31'h0, v});
    check("answer data", exp, r);
  endtask
  task automatic put(input logic [3:0] c, input logic [31:0] d);
    logic v;
    logic [31:0] r;
    sbsr_host_model_inst.xfer(c, d, v, r);
    check("silent command", 32'h0, {31'h0, v});
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic t_reset;
    ask(`SBSR_CMD_ESR_QUERY, 32'h80);
    ask(`SBSR_CMD_ESR_QUERY, 32'h00);
    ask(`SBSR_CMD_ESE_QUERY, 32'h00);
    ask(`SBSR_CMD_SRE_QUERY, 32'h00);
    ask(`SBSR_CMD_STB_QUERY, 32'h00);
    put(4'hF, 32'h0);
    ask(`SBSR_CMD_ESR_QUERY, 32'h20);
  endtask
  task automatic t_events;
    logic [7:0] b;
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      put(`SBSR_CMD_ESE_WRITE, {24'h0, b});
      ask(`SBSR_CMD_ESE_QUERY, {24'h0, b});
      @(negedge sys_clk) std_event_set = b;
      @(negedge sys_clk) std_event_set = 8'h00;
      wait_cyc(2);
      ask(`SBSR_CMD_STB_QUERY, (b & 8'hBD) != 8'h00 ? 32'h20 : 32'h00);
      ask(`SBSR_CMD_ESR_QUERY, {24'h0, b & 8'hBD});
      ask(`SBSR_CMD_STB_QUERY, 32'h00);
    end
  endtask
  task automatic t_srq;
    @(negedge sys_clk) gpib_mode = 1'b1;
    put(`SBSR_CMD_SRE_WRITE, 32'h02);
    put(`SBSR_CMD_PROT_EN_WRITE, 32'h01);
    @(negedge sys_clk) prot_cond = 21'h2;
    @(negedge sys_clk) prot_cond = 21'h0;
    wait_cyc(3);
    ask(`SBSR_CMD_STB_QUERY, 32'h00);
    check("service line", 32'h1, {31'h0, srq_line});
    @(negedge sys_clk) prot_cond = 21'h1;
    @(negedge sys_clk) prot_cond = 21'h0;
    wait_cyc(3);
    check("service line", 32'h0, {31'h0, srq_line});
    ask(`SBSR_CMD_STB_QUERY, 32'h42);
    ask(`SBSR_CMD_SERIAL_POLL, 32'h42);
    ask(`SBSR_CMD_SERIAL_POLL, 32'h02);
    check("service line", 32'h1, {31'h0, srq_line});
    ask(`SBSR_CMD_STB_QUERY, 32'h42);
    ask(`SBSR_CMD_PROT_EV_QUERY, 32'h01);
    ask(`SBSR_CMD_STB_QUERY, 32'h00);
  endtask
  task automatic t_cls;
    @(negedge sys_clk) std_event_set = 8'h01;
    prot_cond = 21'h1;
    err_push = 1'b1;
    err_code = 16'h0007;
    @(negedge sys_clk) std_event_set = 8'h00;
    prot_cond = 21'h0;
    err_push = 1'b0;
    put(`SBSR_CMD_CLEAR_STATUS, 32'h0);
    ask(`SBSR_CMD_ESR_QUERY, 32'h00);
    ask(`SBSR_CMD_STB_QUERY, 32'h00);
    ask(`SBSR_CMD_ERR_QUERY, 32'h00);
    ask(`SBSR_CMD_SRE_QUERY, 32'h02);
    check("service line", 32'h1, {31'h0, srq_line});
  endtask
  task automatic t_mav;
    @(negedge sys_clk) output_message_waiting = 1'b1;
    wait_cyc(2);
    ask(`SBSR_CMD_STB_QUERY, 32'h10);
    put(`SBSR_CMD_SRE_WRITE, 32'h12);
    wait_cyc(2);
    ask(`SBSR_CMD_STB_QUERY, 32'h50);
    ask(`SBSR_CMD_SERIAL_POLL, 32'h50);
    put(`SBSR_CMD_SRE_WRITE, 32'h00);
    @(negedge sys_clk) output_message_waiting = 1'b0;
    wait_cyc(2);
    gpib_mode = 1'b0;
    @(negedge sys_clk) output_message_waiting = 1'b1;
    wait_cyc(2);
    ask(`SBSR_CMD_STB_QUERY, 32'h00);
    put(`SBSR_CMD_SERIAL_POLL, 32'h0);
    output_message_waiting = 1'b0;
  endtask
  task automatic t_queue;
    for (int i = 1; i <= 11; i++) begin
      @(negedge sys_clk);
      err_push = 1'b1;
      err_code = i[15:0];
    end
    @(negedge sys_clk) err_push = 1'b0;
    wait_cyc(2);
    check("queue full", 32'h1, {31'h0, err_full_ff});
    ask(`SBSR_CMD_STB_QUERY, 32'h04);
    for (int i = 1; i <= 10; i++)
      ask(`SBSR_CMD_ERR_QUERY, i);
    ask(`SBSR_CMD_ERR_QUERY, 32'h00);
    wait_cyc(2);
    ask(`SBSR_CMD_STB_QUERY, 32'h00);
  endtask
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset();
    t_events();
    t_srq();
    t_cls();
    t_mav();
    t_queue();
    conclude();
  end
endmodule
`default_nettype wire
